// ===== pkg/dosd_defines.vh
// Constants for the drive output status detection block
`ifndef DOSD_DEFINES_VH
`define DOSD_DEFINES_VH
`define DOSD_FN_RUNNING 6'h00
`define DOSD_FN_FREQ_AGREE 6'h02
`define DOSD_FN_SET_AGREE 6'h03
`define DOSD_FN_FDET1 6'h04
`define DOSD_FN_FDET2 6'h05
`define DOSD_FN_CUR_AGREE 6'h0D
`define DOSD_FN_BRAKE 6'h0E
`define DOSD_FN_CRANE 6'h27
`define DOSD_FN_FREQ_OUT 6'h28
`define DOSD_FN_FDET3 6'h32
`define DOSD_FN_FDET4 6'h33
`define DOSD_FN_FDET5 6'h34
`define DOSD_FN_FDET6 6'h35
`define DOSD_UD_HOLD 2'h0
`define DOSD_UD_CLEAR 2'h1
`define DOSD_UD_STOPADJ 2'h2
`define DOSD_UD_REFRESH 2'h3
`define DOSD_POL_R1_BIT 0
`define DOSD_POL_R2_BIT 1
`define DOSD_LVL_MAX 13'h1766
`define DOSD_WID_MIN 8'h01
`define DOSD_WID_MAX 8'hFF
`define DOSD_CUR_MIN 14'h0001
`define DOSD_CUR_MAX 14'h270F
`define DOSD_DLY_MIN 7'h01
`define DOSD_DLY_MAX 7'h64
`define DOSD_BRK_MAX 16'hE9FC
`define DOSD_CLK_HZ 10000000
`define DOSD_STEP_MS 100
`define DOSD_OFF_DELAY_MS 100
`endif

// ===== hdl/dosd_top.v
// Output status detection for drive relays and photo-coupler output
`include "dosd_defines.vh"

// Behaviour
// - Code 51: on below level2+width2, off once below level2.
// - Code 52: on above level3+width3, off below level3.
// - Code 53: on below level3+width3, off once below level3.
// - Code 39: on when accelerating above primary level plus width.
// - Code 39: off when decelerating below primary level, else hold.
// - Frequency-output function closed while output frequency is produced outside baseblock, else open.
// - Levels accept 0 to 599.0 Hz, widths 0.1 to 25.5 Hz.
// - Primary level and width serve codes 2 to 5 on all outputs.
// - Code 13: on after current exceeds agree level for delay time.
// - Agree level 0.1 to 999.9 A, delay 0.1 to 10.0 s.
// - Current agree output turns off 100 ms after condition clears.
// - Code 14: on when accelerating at or above brake set level.
// - Code 14: off when decelerating below brake release level.
// - Polarity bit 0 relay one, bit 1 relay two; 1 normally closed.
// - UP/DOWN mode 0 stores reference at stop, restores at run.
// - UP/DOWN mode 1 clears reference to zero at stop.
// - UP/DOWN mode 2 allows adjustment while stopped from last value.
// - UP/DOWN mode 3 refreshes reference during acceleration.
// - Code 4: on above primary level plus width, off below level.
module dosd_top #(
    parameter FW = 16,
    parameter CLK_HZ = `DOSD_CLK_HZ
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [FW-1:0] out_freq,
    input wire [FW-1:0] freq_ref,
    input wire [13:0] out_current,
    input wire run_cmd,
    input wire accel,
    input wire decel,
    input wire baseblock,
    input wire [5:0] relay_one_func,
    input wire [5:0] relay_two_func,
    input wire [5:0] photo_func,
    input wire [1:0] relay_type,
    input wire photo_type,
    input wire [12:0] det_level1,
    input wire [7:0] det_width1,
    input wire [12:0] det_level2,
    input wire [7:0] det_width2,
    input wire [12:0] det_level3,
    input wire [7:0] det_width3,
    input wire [13:0] cur_agree_level,
    input wire [6:0] cur_agree_delay,
    input wire [15:0] brake_set_level,
    input wire [15:0] brake_release_level,
    input wire [1:0] updown_mode,
    input wire up_cmd,
    input wire down_cmd,
    output reg relay_one_contact,
    output reg relay_two_contact,
    output reg photo_coupler_output,
    output reg [FW-1:0] updown_ref,
    output reg setting_error
);

// ==========================================
// Timing
// Frequencies are in 0.1 Hz units except the brake levels in 0.01 Hz.
localparam integer STEP_CYC = (CLK_HZ / 1000) * `DOSD_STEP_MS;
localparam integer OFF_CYC = (CLK_HZ / 1000) * `DOSD_OFF_DELAY_MS;
// Wide enough for a 10 s delay at 10 MHz; a much faster clock needs more bits
localparam integer TW = 28;

// ==========================================
// Input registers
// One register stage aligns the measured inputs and status bits to the same edge; settings and up/down commands enter unregistered
reg [FW-1:0] freq_reg;
reg [FW-1:0] fref_reg;
reg [13:0] cur_reg;
reg run_reg;
reg acc_reg;
reg dec_reg;
reg bb_reg;

always @(posedge ref_clk) begin
    if (!rst_n) begin
        freq_reg <= {FW{1'b0}};
        fref_reg <= {FW{1'b0}};
        cur_reg <= 14'h0000;
        run_reg <= 1'b0;
        acc_reg <= 1'b0;
        dec_reg <= 1'b0;
        bb_reg <= 1'b0;
    end else begin
        freq_reg <= out_freq;
        fref_reg <= freq_ref;
        cur_reg <= out_current;
        run_reg <= run_cmd;
        acc_reg <= accel;
        dec_reg <= decel;
        bb_reg <= baseblock;
    end
end

// ==========================================
// Setting range check
// Out-of-range settings are still used as given; the flag only reports them
wire lvl_bad = (det_level1 > `DOSD_LVL_MAX) || (det_level2 > `DOSD_LVL_MAX) ||
    (det_level3 > `DOSD_LVL_MAX);
wire wid_bad = (det_width1 < `DOSD_WID_MIN) || (det_width2 < `DOSD_WID_MIN) ||
    (det_width3 < `DOSD_WID_MIN);
wire cur_bad = (cur_agree_level < `DOSD_CUR_MIN) || (cur_agree_level > `DOSD_CUR_MAX);
wire dly_bad = (cur_agree_delay < `DOSD_DLY_MIN) || (cur_agree_delay > `DOSD_DLY_MAX);
wire brk_bad = (brake_set_level > `DOSD_BRK_MAX) ||
    (brake_release_level > `DOSD_BRK_MAX);

always @(posedge ref_clk) begin
    if (!rst_n) begin
        setting_error <= 1'b0;
    end else begin
        setting_error <= lvl_bad || wid_bad ||
            cur_bad || dly_bad ||
            brk_bad;
    end
end

// ==========================================
// Frequency thresholds, one bit wider to avoid wrap on level plus width
// Widths are never negative, so each upper edge never sits below its level
wire [FW:0] f_ext = {1'b0, freq_reg};
wire [FW:0] lo1 = {{(FW-12){1'b0}}, det_level1};
wire [FW:0] hi1 = lo1 + {{(FW-7){1'b0}}, det_width1};
wire [FW:0] lo2 = {{(FW-12){1'b0}}, det_level2};
wire [FW:0] hi2 = lo2 + {{(FW-7){1'b0}}, det_width2};
wire [FW:0] lo3 = {{(FW-12){1'b0}}, det_level3};
wire [FW:0] hi3 = lo3 + {{(FW-7){1'b0}}, det_width3};
wire [FW:0] fr_ext = {1'b0, fref_reg};
wire [FW:0] diff_ref = (f_ext > fr_ext) ? (f_ext - fr_ext) : (fr_ext - f_ext);
wire [FW:0] diff_lvl = (f_ext > lo1) ? (f_ext - lo1) : (lo1 - f_ext);
wire [FW:0] w1 = {{(FW-7){1'b0}}, det_width1};
// Brake levels are 0.01 Hz; scale frequency by ten to compare
wire [FW+4:0] f_centi = {4'h0, f_ext} * 5'h0A;
wire [FW+4:0] brk_set = {{(FW-11){1'b0}}, brake_set_level};
wire [FW+4:0] brk_rel = {{(FW-11){1'b0}}, brake_release_level};

// ==========================================
// Hysteresis detectors
reg fdet1_reg;
reg fdet3_reg;
reg fdet5_reg;
reg crane_reg;
reg brake_reg;
// Detectors 2, 4, 6 are on from below; they only arm once the band is reached
reg fdet2_reg;
reg fdet4_reg;
reg fdet6_reg;

always @(posedge ref_clk) begin
    if (!rst_n) begin
        fdet1_reg <= 1'b0;
        fdet3_reg <= 1'b0;
        fdet5_reg <= 1'b0;
        fdet2_reg <= 1'b0;
        fdet4_reg <= 1'b0;
        fdet6_reg <= 1'b0;
        crane_reg <= 1'b0;
        brake_reg <= 1'b0;
    end else begin
        // Code 4
        if (f_ext > hi1) fdet1_reg <= 1'b1;
        else if (f_ext < lo1) fdet1_reg <= 1'b0;
        // Code 50
        if (f_ext > hi2) fdet3_reg <= 1'b1;
        else if (f_ext < lo2) fdet3_reg <= 1'b0;
        // Code 52
        if (f_ext > hi3) fdet5_reg <= 1'b1;
        else if (f_ext < lo3) fdet5_reg <= 1'b0;
        // Active inside band up to level+width, off once below level
        // Code 5
        fdet2_reg <= (f_ext >= lo1) && (f_ext < hi1);
        // Code 51
        fdet4_reg <= (f_ext >= lo2) && (f_ext < hi2);
        // Code 53
        fdet6_reg <= (f_ext >= lo3) && (f_ext < hi3);
        // Code 39 holds its state outside accel and decel
        if (acc_reg && (f_ext > hi1)) crane_reg <= 1'b1;
        else if (dec_reg && (f_ext < lo1)) crane_reg <= 1'b0;
        // Code 14; set is tested first, so it wins when accel and decel are both high
        if (acc_reg && (f_centi >= brk_set)) brake_reg <= 1'b1;
        else if (dec_reg && (f_centi < brk_rel)) brake_reg <= 1'b0;
    end
end

// ==========================================
// Current agree with on-delay and fixed off-delay
// Current rising again cancels the off count, so a brief dip never drops the relay
// A zero delay setting closes at once; the range flag reports it
reg [TW-1:0] on_cnt_reg;
reg [TW-1:0] off_cnt_reg;
reg cur_agree_reg;
wire cur_over = cur_reg > cur_agree_level;
wire [TW-1:0] on_target = cur_agree_delay * STEP_CYC[TW-1:0];

always @(posedge ref_clk) begin
    if (!rst_n) begin
        on_cnt_reg <= {TW{1'b0}};
        off_cnt_reg <= {TW{1'b0}};
        cur_agree_reg <= 1'b0;
    end else if (cur_over) begin
        off_cnt_reg <= {TW{1'b0}};
        if (on_cnt_reg >= on_target) begin
            cur_agree_reg <= 1'b1;
        end else begin
            on_cnt_reg <= on_cnt_reg + 1'b1;
        end
    end else begin
        on_cnt_reg <= {TW{1'b0}};
        if (cur_agree_reg) begin
            if (off_cnt_reg >= OFF_CYC[TW-1:0] - 1'b1) begin
                cur_agree_reg <= 1'b0;
                off_cnt_reg <= {TW{1'b0}};
            end else begin
                off_cnt_reg <= off_cnt_reg + 1'b1;
            end
        end
    end
end

// ==========================================
// Function selection
wire running = run_reg || (freq_reg != {FW{1'b0}});
// Baseblock opens the frequency output even while frequency is still reported
wire freq_out = (freq_reg != {FW{1'b0}}) && !bb_reg;

function sel_fn;
    input [5:0] fn;
    input c_run;
    input c_fa;
    input c_sa;
    input c_d1;
    input c_d2;
    input c_ca;
    input c_br;
    input c_cr;
    input c_fo;
    input c_d3;
    input c_d4;
    input c_d5;
    input c_d6;
    // Unlisted codes stay inactive; a normally closed polarity still energises the contact
    begin
        case (fn)
            `DOSD_FN_RUNNING: sel_fn = c_run;
            `DOSD_FN_FREQ_AGREE: sel_fn = c_fa;
            `DOSD_FN_SET_AGREE: sel_fn = c_sa;
            `DOSD_FN_FDET1: sel_fn = c_d1;
            `DOSD_FN_FDET2: sel_fn = c_d2;
            `DOSD_FN_CUR_AGREE: sel_fn = c_ca;
            `DOSD_FN_BRAKE: sel_fn = c_br;
            `DOSD_FN_CRANE: sel_fn = c_cr;
            `DOSD_FN_FREQ_OUT: sel_fn = c_fo;
            `DOSD_FN_FDET3: sel_fn = c_d3;
            `DOSD_FN_FDET4: sel_fn = c_d4;
            `DOSD_FN_FDET5: sel_fn = c_d5;
            `DOSD_FN_FDET6: sel_fn = c_d6;
            default: sel_fn = 1'b0;
        endcase
    end
endfunction

// ==========================================
// Agree conditions, both using the primary width on either side of the target
wire fa = running && (diff_ref <= w1);
wire sa = diff_lvl <= w1;
// Relay one
wire st_r1 = sel_fn(relay_one_func, running, fa, sa, fdet1_reg, fdet2_reg, cur_agree_reg,
    brake_reg, crane_reg, freq_out, fdet3_reg, fdet4_reg, fdet5_reg, fdet6_reg);
// Relay two
wire st_r2 = sel_fn(relay_two_func, running, fa, sa, fdet1_reg, fdet2_reg, cur_agree_reg,
    brake_reg, crane_reg, freq_out, fdet3_reg, fdet4_reg, fdet5_reg, fdet6_reg);
// Photo-coupler
wire st_ph = sel_fn(photo_func, running, fa, sa, fdet1_reg, fdet2_reg, cur_agree_reg,
    brake_reg, crane_reg, freq_out, fdet3_reg, fdet4_reg, fdet5_reg, fdet6_reg);

// ==========================================
// Output polarity
// Polarity is not applied during reset so contacts stay de-energised there
always @(posedge ref_clk) begin
    if (!rst_n) begin
        relay_one_contact <= 1'b0;
        relay_two_contact <= 1'b0;
        photo_coupler_output <= 1'b0;
    end else begin
        relay_one_contact <= st_r1 ^ relay_type[`DOSD_POL_R1_BIT];
        relay_two_contact <= st_r2 ^ relay_type[`DOSD_POL_R2_BIT];
        photo_coupler_output <= st_ph ^ photo_type;
    end
end

// ==========================================
// UP/DOWN frequency reference
reg run_d_reg;
reg [FW-1:0] stored_reg;
// Edges come from the registered run level, one edge behind the pin
wire run_fall = run_d_reg && !run_reg;
wire run_rise = !run_d_reg && run_reg;
wire adj_ok = run_reg || (updown_mode == `DOSD_UD_STOPADJ);

always @(posedge ref_clk) begin
    if (!rst_n) begin
        run_d_reg <= 1'b0;
        stored_reg <= {FW{1'b0}};
        updown_ref <= {FW{1'b0}};
    end else begin
        run_d_reg <= run_reg;
        if (run_fall) begin
            case (updown_mode)
                `DOSD_UD_HOLD: stored_reg <= updown_ref;
                `DOSD_UD_CLEAR: begin
                    stored_reg <= {FW{1'b0}};
                    updown_ref <= {FW{1'b0}};
                end
                default: stored_reg <= updown_ref;
            endcase
        end else if (run_rise && (updown_mode == `DOSD_UD_HOLD)) begin
            updown_ref <= stored_reg;
        end else if ((updown_mode == `DOSD_UD_REFRESH) && run_reg && acc_reg) begin
            updown_ref <= freq_reg;
        // Up and down together cancel; both ends saturate
        end else if (adj_ok && up_cmd && !down_cmd && (updown_ref != {FW{1'b1}})) begin
            updown_ref <= updown_ref + 1'b1;
            // A change made while stopped is what the next run in hold mode resumes
            if (!run_reg) begin
                stored_reg <= updown_ref + 1'b1;
            end
        end else if (adj_ok && down_cmd && !up_cmd && (updown_ref != {FW{1'b0}})) begin
            updown_ref <= updown_ref - 1'b1;
            if (!run_reg) begin
                stored_reg <= updown_ref - 1'b1;
            end
        end
    end
end

endmodule

// ===== test/dosd_props.sv
// Port-level checks of the output status detector
module dosd_props #(
    parameter FW = 16,
    parameter CLK_HZ = 10000000
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [FW-1:0] out_freq,
    input wire accel,
    input wire decel,
    input wire baseblock,
    input wire [5:0] relay_one_func,
    input wire [5:0] relay_two_func,
    input wire [5:0] photo_func,
    input wire [1:0] relay_type,
    input wire photo_type,
    input wire [12:0] det_level1,
    input wire [7:0] det_width1,
    input wire [12:0] det_level3,
    input wire [7:0] det_width3,
    input wire [15:0] brake_set_level,
    input wire [15:0] brake_release_level,
    input wire relay_one_contact,
    input wire relay_two_contact,
    input wire photo_coupler_output
);
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // Helpers; the pipeline is three edges deep, so causes must stand four
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    wire [15:0] h1 = det_level1 + det_width1;
    wire [15:0] h3 = det_level3 + det_width3;
    wire [19:0] f100 = out_freq * 20'h0000A;
    wire f4 = relay_one_func == 6'h04 && !relay_type[0];
    wire c39 = relay_one_func == 6'h27 && !relay_type[0];
    wire b14 = relay_two_func == 6'h0E && !relay_type[1];
    wire p40 = photo_func == 6'h28 && !photo_type;
    sequence s_crane_up;
        (c39 && accel && out_freq > h1)[*4];
    endsequence
    sequence s_crane_idle;
        (c39 && !accel && !decel)[*5];
    endsequence
    // ==========================================
    // Assertions
    AST_RST: assert property (disable iff (1'b0) !rst_n |=> !relay_one_contact &&
        !relay_two_contact && !photo_coupler_output) else $error("contacts not cleared");
    AST_FD1_ON: assert property ((f4 && out_freq > h1)[*4] |=> relay_one_contact)
        else $error("detection 1 not on");
    AST_FD1_OFF: assert property ((f4 && out_freq < det_level1)[*4] |=> !relay_one_contact)
        else $error("detection 1 not off");
    AST_CR_ON: assert property (s_crane_up |=> relay_one_contact)
        else $error("crane detection not on");
    AST_CR_OFF: assert property ((c39 && decel && out_freq < det_level1)[*4]
        |=> !relay_one_contact) else $error("crane detection not off");
    AST_CR_HOLD: assert property (s_crane_idle |=> $stable(relay_one_contact))
        else $error("crane detection moved while idle");
    AST_BR_ON: assert property ((b14 && accel && f100 >= brake_set_level)[*4]
        |=> relay_two_contact) else $error("brake not on");
    AST_BR_OFF: assert property ((b14 && decel && f100 < brake_release_level)[*4]
        |=> !relay_two_contact) else $error("brake not off");
    AST_FO_BB: assert property ((p40 && baseblock)[*4] |=> !photo_coupler_output)
        else $error("frequency output on in baseblock");
    AST_FO_RUN: assert property ((p40 && !baseblock && out_freq != 0)[*4]
        |=> photo_coupler_output) else $error("frequency output not on");
    AST_POL: assert property ((relay_two_func == 6'h3F && relay_type[1])[*4]
        |=> relay_two_contact) else $error("relay two not inverted");
    AST_FD5: assert property ((relay_two_func == 6'h34 && !relay_type[1] && out_freq > h3)[*4]
        |=> relay_two_contact) else $error("detection 5 not on");
endmodule

bind dosd_top dosd_props #(.FW(FW), .CLK_HZ(CLK_HZ)) u_props (.ref_clk, .rst_n, .out_freq,
    .accel, .decel, .baseblock, .relay_one_func, .relay_two_func, .photo_func, .relay_type,
    .photo_type, .det_level1, .det_width1, .det_level3, .det_width3, .brake_set_level,
    .brake_release_level, .relay_one_contact, .relay_two_contact, .photo_coupler_output);

// ===== test/dosd_contact_model.sv
// Relay and photo-coupler contact model seen by the bench
module dosd_contact_model (
    input wire relay_one_contact,
    input wire relay_two_contact,
    input wire photo_coupler_output,
    output wire [2:0] closed
);
    timeunit 1ns;
    timeprecision 1ns;
    // A high level closes the contact; polarity is applied upstream
    assign closed = {photo_coupler_output, relay_two_contact, relay_one_contact};
endmodule

// ===== test/dosd_top_tb.sv
// Self-checking bench for the output status detector
module dosd_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'h0, rst_n = 1'h0, run_cmd = 1'h0, accel = 1'h0, decel = 1'h0;
    logic baseblock = 1'h0, up_cmd = 1'h0, down_cmd = 1'h0, photo_type = 1'h0;
    logic [15:0] out_freq = 16'h0000, freq_ref = 16'h0000, eref = 16'h0000;
    logic [15:0] brake_set_level = 16'h0BB8, brake_release_level = 16'h07D0;
    logic [13:0] out_current = 14'h0000, cur_agree_level = 14'h0064;
    logic [12:0] det_level1 = 13'h01F4, det_level2 = 13'h012C, det_level3 = 13'h0320;
    logic [7:0] det_width1 = 8'h14, det_width2 = 8'h14, det_width3 = 8'h1E;
    logic [6:0] cur_agree_delay = 7'h02;
    logic [5:0] relay_one_func = 6'h3F, relay_two_func = 6'h3F, photo_func = 6'h3F;
    logic [1:0] relay_type = 2'h0, updown_mode = 2'h2;
    logic [31:0] r;
    logic [19:0] notes[$];
    logic [19:0] exp_v;
    wire relay_one_contact, relay_two_contact, photo_coupler_output, setting_error;
    wire [15:0] updown_ref;
    wire [2:0] st;
    integer fail_count = 0, num_checks = 0, seed = 32'he93dd225, i;
    event chk_ev;

    // Delays shortened: 0.1 s becomes 1000 cycles
    dosd_top #(.FW(16), .CLK_HZ(10000)) uut (.ref_clk, .rst_n, .out_freq, .freq_ref,
        .out_current, .run_cmd, .accel, .decel, .baseblock, .relay_one_func, .relay_two_func,
        .photo_func, .relay_type, .photo_type, .det_level1, .det_width1, .det_level2,
        .det_width2, .det_level3, .det_width3, .cur_agree_level, .cur_agree_delay,
        .brake_set_level, .brake_release_level, .updown_mode, .up_cmd, .down_cmd,
        .relay_one_contact, .relay_two_contact, .photo_coupler_output, .updown_ref,
        .setting_error);
    dosd_contact_model pm (.relay_one_contact, .relay_two_contact, .photo_coupler_output,
        .closed(st));

    always #50 ref_clk = ~ref_clk;

    // ==========================================
    // Drivers and result watcher
    task automatic cfg(input [5:0] a, input [5:0] b, input [5:0] c, input [1:0] t,
        input p);
        @(posedge ref_clk);
        relay_one_func <= a;
        relay_two_func <= b;
        photo_func <= c;
        relay_type <= t;
        photo_type <= p;
    endtask
    // m is {accel, decel, baseblock}; e is {error, photo, relay two, relay one}
    task automatic step(input [15:0] f, input [2:0] m, input [3:0] e, input integer w);
        @(posedge ref_clk);
        out_freq <= f;
        {accel, decel, baseblock} <= m;
        repeat (w) @(posedge ref_clk);
        notes.push_back({e, eref});
        #10 -> chk_ev;
    endtask
    task automatic ud(input [1:0] m, input [15:0] e);
        @(posedge ref_clk);
        updown_mode <= m;
        run_cmd <= 1'h1;
        repeat (5) @(posedge ref_clk);
        run_cmd <= 1'h0;
        eref = e;
        step(16'h0000, 3'h0, 4'h0, 6);
    endtask
    task automatic wrap_up;
        if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    always @(chk_ev) begin
        exp_v = notes.pop_front();
        num_checks++;
        if (exp_v !== {setting_error, st, updown_ref}) begin
            fail_count++;
            $display("[ERR] outputs expected %h seen %h", exp_v, {setting_error, st, updown_ref});
        end
    end

    initial begin
        #2000000;
        fail_count++;
        wrap_up();
    end

    // ==========================================
    // Scenarios
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'h1;
        cfg(6'h04, 6'h34, 6'h33, 2'h0, 1'h0);
        step(16'h01FE, 3'h0, 4'h0, 6);
        step(16'h0212, 3'h0, 4'h1, 6);
        step(16'h01F9, 3'h0, 4'h1, 6);
        step(16'h0136, 3'h0, 4'h4, 6);
        step(16'h0122, 3'h0, 4'h0, 6);
        step(16'h0352, 3'h0, 4'h3, 6);
        step(16'h032A, 3'h0, 4'h3, 6);
        step(16'h0316, 3'h0, 4'h1, 6);
        cfg(6'h02, 6'h03, 6'h32, 2'h0, 1'h0);
        freq_ref <= 16'h01F4;
        step(16'h01F9, 3'h0, 4'h7, 6);
        step(16'h0136, 3'h0, 4'h4, 6);
        step(16'h0122, 3'h0, 4'h0, 6);
        cfg(6'h00, 6'h05, 6'h3F, 2'h0, 1'h0);
        step(16'h01FE, 3'h0, 4'h3, 6);
        step(16'h0000, 3'h0, 4'h0, 6);
        cfg(6'h27, 6'h0E, 6'h28, 2'h0, 1'h0);
        step(16'h0064, 3'h2, 4'h4, 6);
        step(16'h012C, 3'h4, 4'h6, 6);
        step(16'h0212, 3'h4, 4'h7, 6);
        step(16'h0190, 3'h1, 4'h3, 6);
        step(16'h00FA, 3'h2, 4'h6, 6);
        step(16'h0096, 3'h2, 4'h4, 6);
        step(16'h0000, 3'h0, 4'h0, 6);
        cfg(6'h35, 6'h3F, 6'h3F, 2'h3, 1'h1);
        step(16'h032A, 3'h0, 4'h6, 6);
        step(16'h0064, 3'h0, 4'h7, 6);
        cfg(6'h0D, 6'h3F, 6'h3F, 2'h0, 1'h0);
        @(posedge ref_clk);
        out_current <= 14'h0096;
        step(16'h0000, 3'h0, 4'h0, 1990);
        step(16'h0000, 3'h0, 4'h1, 20);
        @(posedge ref_clk);
        out_current <= 14'h0032;
        step(16'h0000, 3'h0, 4'h1, 990);
        step(16'h0000, 3'h0, 4'h0, 20);
        cfg(6'h3F, 6'h3F, 6'h3F, 2'h0, 1'h0);
        for (i = 0; i < 8; i++) begin
            r = $random(seed);
            @(posedge ref_clk);
            det_level2 <= r[12:0];
            det_width2 <= r[20:13];
            step(16'h0000, 3'h0, {r[12:0] > 13'h1766 || r[20:13] == 8'h00, 3'h0}, 6);
        end
        @(posedge ref_clk);
        det_level2 <= 13'h012C;
        det_width2 <= 8'h14;
        up_cmd <= 1'h1;
        repeat (10) @(posedge ref_clk);
        up_cmd <= 1'h0;
        down_cmd <= 1'h1;
        repeat (3) @(posedge ref_clk);
        down_cmd <= 1'h0;
        eref = 16'h0007;
        step(16'h0000, 3'h0, 4'h0, 6);
        ud(2'h0, 16'h0007);
        ud(2'h1, 16'h0000);
        @(posedge ref_clk);
        updown_mode <= 2'h3;
        run_cmd <= 1'h1;
        eref = 16'h00FA;
        step(16'h00FA, 3'h4, 4'h0, 6);
        @(posedge ref_clk);
        wrap_up();
    end
endmodule
